// File: rtl/pmcs_pkg.sv
/*
 * Shared constants and carriers for the power management control/status
 * and subsystem capability header register block.
 * Assumes one clock domain; configuration requests come from logic on it.
 */
package pmcs_pkg;

	// Configuration offsets (byte addresses of aligned dwords)
	localparam logic [7:0]  PMCS_PM_CS_OFF   = 8'h84;
	localparam logic [7:0]  PMCS_SSCAP_OFF   = 8'h88;

	// Capability header contents
	localparam logic [7:0]  PMCS_CAP_ID      = 8'h0D;
	localparam logic [7:0]  PMCS_NEXT_PTR    = 8'h80;
	localparam logic [31:0] PMCS_SSCAP_RESET = 32'h0000800D;

	// Control/status field positions and reset values
	localparam int          PMCS_PSTATE_LSB  = 0;
	localparam int          PMCS_WAKE_EN_BIT = 8;
	localparam int          PMCS_WAKE_ST_BIT = 15;
	localparam logic        PMCS_WAKE_EN_RST = 1'b0;

	// Response latency of a configuration access, in clock cycles
	localparam int          PMCS_ACK_CYCLES  = 1;

	typedef enum logic [1:0] {
		PMCS_PS_FULL   = 2'b00,
		PMCS_PS_LIGHT  = 2'b01,
		PMCS_PS_MID    = 2'b10,
		PMCS_PS_SLEEP  = 2'b11
	} pmcs_pstate_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} pmcs_cfg_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} pmcs_cfg_rsp_t;

endpackage : pmcs_pkg

// File: rtl/pmcs_pstate.sv
/*
 * Power-state field holder: keeps the two-bit state, takes only the
 * supported codes and drops the rest without any change.
 * Assumes the caller qualifies wr_en with address and byte lane 0.
 */
`timescale 1ns/100ps
module pmcs_pstate (
	input  wire logic                  ref_clk,   // System clock
	input  wire logic                  rst,       // Async reset, active high
	input  wire logic                  func_rst,  // Function reset, sync
	input  wire logic                  wr_en,     // Write to state field
	input  wire logic [1:0]            wr_code,   // Code written
	output pmcs_pkg::pmcs_pstate_t     state_q    // Current power state
);
	import pmcs_pkg::*;

	pmcs_pstate_t state_d;

	always_comb begin
		state_d = state_q;
		if (func_rst) begin
			state_d = PMCS_PS_FULL;
		end else if (wr_en) begin
			unique case (wr_code)
				PMCS_PS_FULL:  state_d = PMCS_PS_FULL;
				PMCS_PS_SLEEP: state_d = PMCS_PS_SLEEP;
				default:       state_d = state_q;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= PMCS_PS_FULL;
		end else begin
			state_q <= state_d;
		end
	end

endmodule : pmcs_pstate

// File: rtl/pmcs_regs.sv
/*
 * Configuration register logic of one bridge function: power management
 * control/status and the subsystem capability header, plus gating of
 * interrupts and memory-mapped cycles while in deep sleep.
 * Reserved bits of both words read zero and drop writes.
 * Assumes cfg requests are one-cycle pulses from logic on ref_clk.
 * Assumes irq_in, mmr_req and tgt_req also come from logic on ref_clk.
 */
`timescale 1ns/100ps

module pmcs_regs (
	input  wire logic                  ref_clk,     // 100 MHz clock
	input  wire logic                  rst,         // Async hw reset
	input  wire logic                  func_rst,    // Function reset
	input  pmcs_pkg::pmcs_cfg_req_t    cfg_req,     // Config request
	output pmcs_pkg::pmcs_cfg_rsp_t    cfg_rsp,     // Config answer
	input  wire logic                  irq_in,      // Function interrupt
	output logic                       irq_out,     // Gated interrupt
	input  wire logic                  mmr_req,     // Memory cycle request
	output logic                       mmr_claim,   // Memory cycle claimed
	input  wire logic                  tgt_req,     // Other target request
	output logic                       tgt_claim,   // Other target claimed
	output pmcs_pkg::pmcs_pstate_t     power_state, // Current power state
	output logic                       deep_sleep,  // In deep sleep
	output logic                       wake_en      // Wake enable, no effect
);
	import pmcs_pkg::*;

	// Request decode
	logic          rd_pm;
	logic          rd_cap;
	logic          wr_pm;
	logic          wr_state;
	logic          wr_wake;
	logic [31:0]   pm_cs_cur;
	logic [31:0]   pm_cs_new;

	// Answer strobe
	logic          ack_q;
	logic          ack_d;

	// Read data
	logic [31:0]   rdata_q;
	logic [31:0]   rdata_d;

	// Wake enable, sticky
	logic          wake_en_q;
	logic          wake_en_d;

	// Power state and sleep gating
	pmcs_pstate_t  state_q;
	logic          sleeping;

	// Dword match of a byte address against a register offset
	function automatic logic dword_hit(
		input logic [7:0] addr,
		input logic [7:0] off
	);
		return (addr[7:2] == off[7:2]);
	endfunction : dword_hit

	// Live request of one direction to one register
	function automatic logic cfg_access(
		input pmcs_cfg_req_t rq,
		input logic [7:0]    off,
		input logic          write
	);
		return rq.req && (rq.we == write) && dword_hit(rq.addr, off);
	endfunction : cfg_access

	// Control/status word as software reads it
	function automatic logic [31:0] pm_cs_image(
		input pmcs_pstate_t st,
		input logic         wen
	);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[PMCS_PSTATE_LSB +: 2] = st;
		v[PMCS_WAKE_EN_BIT]     = wen;
		v[PMCS_WAKE_ST_BIT]     = 1'b0;
		return v;
	endfunction : pm_cs_image

	// Bits of the control/status word that software may change
	function automatic logic [31:0] pm_cs_wmask();
		logic [31:0] m;
		m = 32'h0000_0000;
		m[PMCS_PSTATE_LSB +: 2] = 2'b11;
		m[PMCS_WAKE_EN_BIT]     = 1'b1;
		return m;
	endfunction : pm_cs_wmask

	// Byte-lane merge of a write; read-only bits keep their value
	function automatic logic [31:0] lane_merge(
		input logic [31:0] cur,
		input logic [31:0] wd,
		input logic [3:0]  be,
		input logic [31:0] wmask
	);
		logic [31:0] keep;
		keep = ~wmask;
		for (int i = 0; i < 4; i++) begin
			if (!be[i]) begin
				keep[8*i +: 8] = 8'hFF;
			end
		end
		return (cur & keep) | (wd & ~keep);
	endfunction : lane_merge

	// Capability header word; upper half reserved
	function automatic logic [31:0] cap_image();
		logic [31:0] v;
		v        = PMCS_SSCAP_RESET;
		v[31:16] = 16'h0000;
		v[15:8]  = PMCS_NEXT_PTR;
		v[7:0]   = PMCS_CAP_ID;
		return v;
	endfunction : cap_image

	// Pass a request only outside deep sleep
	function automatic logic awake_only(
		input logic rq,
		input logic slp
	);
		return rq & ~slp;
	endfunction : awake_only

	assign rd_pm     = cfg_access(cfg_req, PMCS_PM_CS_OFF, 1'b0);
	assign rd_cap    = cfg_access(cfg_req, PMCS_SSCAP_OFF, 1'b0);
	assign wr_pm     = cfg_access(cfg_req, PMCS_PM_CS_OFF, 1'b1);
	assign wr_state  = wr_pm & cfg_req.be[0];
	assign wr_wake   = wr_pm & cfg_req.be[1];
	assign pm_cs_cur = pm_cs_image(state_q, wake_en_q);
	assign pm_cs_new = lane_merge(pm_cs_cur, cfg_req.wdata, cfg_req.be,
		pm_cs_wmask());

	// Unsupported codes are dropped inside the state holder
	pmcs_pstate u_pstate (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.func_rst (func_rst),
		.wr_en    (wr_state),
		.wr_code  (pm_cs_new[PMCS_PSTATE_LSB +: 2]),
		.state_q  (state_q)
	);

	// Every config request is answered, whatever the power state
	always_comb begin
		ack_d = cfg_req.req;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= ack_d;
		end
	end

	// Reads load the addressed word; writes and holes load zero
	always_comb begin
		rdata_d = rdata_q;
		if (cfg_req.req) begin
			rdata_d = 32'h0000_0000;
		end
		if (rd_pm) begin
			rdata_d = pm_cs_cur;
		end else if (rd_cap) begin
			rdata_d = cap_image();
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Sticky enable survives function reset; only hw reset clears it
	always_comb begin
		wake_en_d = wake_en_q;
		if (wr_wake) begin
			wake_en_d = pm_cs_new[PMCS_WAKE_EN_BIT];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wake_en_q <= PMCS_WAKE_EN_RST;
		end else begin
			wake_en_q <= wake_en_d;
		end
	end

	// Interrupts and non-config cycles are shut out in deep sleep
	always_comb begin
		sleeping  = (state_q == PMCS_PS_SLEEP);
		irq_out   = awake_only(irq_in, sleeping);
		mmr_claim = awake_only(mmr_req, sleeping);
		tgt_claim = awake_only(tgt_req, sleeping);
	end

	assign deep_sleep    = sleeping;
	assign power_state   = state_q;
	assign wake_en       = wake_en_q;
	assign cfg_rsp.ack   = ack_q;
	assign cfg_rsp.rdata = rdata_q;

endmodule : pmcs_regs

// File: bench/pmcs_regs_assertions.sv
/* Port checker for pmcs_regs.
   Assumes it is bound to pmcs_regs on its single clock. */
`timescale 1ns/100ps
module pmcs_regs_assertions (
	input logic                    ref_clk,     // Clock
	input logic                    rst,         // Reset
	input logic                    func_rst,    // Function reset
	input pmcs_pkg::pmcs_cfg_req_t cfg_req,     // Request
	input pmcs_pkg::pmcs_cfg_rsp_t cfg_rsp,     // Answer
	input logic                    irq_in,      // Interrupt in
	input logic                    irq_out,     // Interrupt out
	input logic                    mmr_req,     // Memory cycle
	input logic                    mmr_claim,   // Memory claim
	input logic                    tgt_req,     // Target cycle
	input logic                    tgt_claim,   // Target claim
	input pmcs_pkg::pmcs_pstate_t  power_state, // State
	input logic                    deep_sleep,  // Sleep flag
	input logic                    wake_en      // Wake enable
);
	import pmcs_pkg::*;
	logic cs_hit;
	assign cs_hit = cfg_req.req && cfg_req.addr == PMCS_PM_CS_OFF;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_ack; cfg_req.req |=> cfg_rsp.ack; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_cap; cfg_req.req && !cfg_req.we
		&& cfg_req.addr == PMCS_SSCAP_OFF
		|=> cfg_rsp.rdata == PMCS_SSCAP_RESET; endproperty
	a_cap: assert property (p_cap) else $error("bad cap");
	property p_wr0; cfg_req.req && cfg_req.we
		|=> cfg_rsp.ack && cfg_rsp.rdata == 32'h0; endproperty
	a_wr0: assert property (p_wr0) else $error("write answer");
	property p_res; cs_hit |=> cfg_rsp.rdata[31:9] == 23'h0
		&& cfg_rsp.rdata[7:2] == 6'h0; endproperty
	a_res: assert property (p_res) else $error("bad ro");
	property p_bad; cs_hit && cfg_req.we && cfg_req.be[0]
		&& ^cfg_req.wdata[1:0] && !func_rst |=> $stable(power_state);
	endproperty
	a_bad: assert property (p_bad) else $error("bad code");
	property p_wake; cs_hit && cfg_req.we && cfg_req.be[1]
		|=> wake_en == $past(cfg_req.wdata[8]); endproperty
	a_wake: assert property (p_wake) else $error("wake");
	property p_ds; deep_sleep == (power_state == PMCS_PS_SLEEP); endproperty
	a_ds: assert property (p_ds) else $error("sleep flag");
	property p_irq; irq_out == (irq_in && !deep_sleep); endproperty
	a_irq: assert property (p_irq) else $error("irq gate");
	property p_gate; mmr_claim == (mmr_req && !deep_sleep)
		&& tgt_claim == (tgt_req && !deep_sleep); endproperty
	a_gate: assert property (p_gate) else $error("claim");
endmodule : pmcs_regs_assertions
bind pmcs_regs pmcs_regs_assertions u_pmcs_regs_assertions (
	.ref_clk     (ref_clk),
	.rst         (rst),
	.func_rst    (func_rst),
	.cfg_req     (cfg_req),
	.cfg_rsp     (cfg_rsp),
	.irq_in      (irq_in),
	.irq_out     (irq_out),
	.mmr_req     (mmr_req),
	.mmr_claim   (mmr_claim),
	.tgt_req     (tgt_req),
	.tgt_claim   (tgt_claim),
	.power_state (power_state),
	.deep_sleep  (deep_sleep),
	.wake_en     (wake_en)
);

// File: bench/tb_top.sv
/* Self-checking bench for pmcs_regs.
   Assumes the package, design and checker are compiled first. */
`timescale 1ns/100ps
module tb_top;
	import pmcs_pkg::*;
	typedef struct {logic [7:0] a; logic [3:0] b;
		logic [31:0] d, e;} pmcs_row_t;
	logic ref_clk = 0, rst = 1, func_rst = 0;
	logic irq_in = 1, mmr_req = 1, tgt_req = 1;
	logic irq_out, mmr_claim, tgt_claim, deep_sleep, wake_en;
	pmcs_cfg_req_t cfg_req = '0;
	pmcs_cfg_rsp_t cfg_rsp;
	pmcs_pstate_t power_state;
	int miscompares = 0, checks_done = 0, cycles = 0;
	pmcs_row_t rows [6] = '{'{8'h84, 4'hF, 32'hFFFFFFFF, 32'h103},
		'{8'h84, 4'h1, 32'h1, 32'h103}, '{8'h84, 4'h1, 32'h2, 32'h103},
		'{8'h84, 4'h3, 32'h0, 32'h0}, '{8'h88, 4'hF, 32'hFFFFFFFF, 32'h800D},
		'{8'h40, 4'hF, 32'hFFFFFFFF, 32'h0}};
	pmcs_regs u_pmcs_regs (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.func_rst    (func_rst),
		.cfg_req     (cfg_req),
		.cfg_rsp     (cfg_rsp),
		.irq_in      (irq_in),
		.irq_out     (irq_out),
		.mmr_req     (mmr_req),
		.mmr_claim   (mmr_claim),
		.tgt_req     (tgt_req),
		.tgt_claim   (tgt_claim),
		.power_state (power_state),
		.deep_sleep  (deep_sleep),
		.wake_en     (wake_en)
	);
	always #5 ref_clk = ~ref_clk;
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h exp %h", $time, s, e);
		end
	endtask : chk
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	task cfg(input logic w, input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d);
		cfg_req = '{1'b1, w, a, b, d};
		@(negedge ref_clk);
		chk({31'h0, cfg_rsp.ack}, 32'h1);
		cfg_req.req = 1'b0;
		@(negedge ref_clk);
	endtask : cfg
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			complete_run();
		end
	end
	initial begin
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		chk({power_state, wake_en, deep_sleep, cfg_rsp.ack}, 5'h00);
		cfg(1'b0, 8'h84, 4'hF, 32'h0);
		chk(cfg_rsp.rdata, 32'h0);
		$display("reset test done");
		foreach (rows[i]) begin
			cfg(1'b1, rows[i].a, rows[i].b, rows[i].d);
			cfg(1'b0, rows[i].a, 4'hF, 32'h0);
			chk(cfg_rsp.rdata, rows[i].e);
		end
		chk({irq_out, mmr_claim, tgt_claim, deep_sleep}, 4'hE);
		$display("row test done");
		cfg(1'b1, 8'h84, 4'h3, 32'h103);
		chk({irq_out, mmr_claim, tgt_claim, deep_sleep}, 4'h1);
		cfg(1'b0, 8'h88, 4'hF, 32'h0);
		chk(cfg_rsp.rdata, 32'h800D);
		func_rst = 1'b1;
		@(negedge ref_clk);
		func_rst = 1'b0;
		chk({power_state, wake_en, irq_out}, 4'h3);
		cfg(1'b1, 8'h84, 4'h3, 32'h103);
		rst = 1'b1;
		@(negedge ref_clk);
		rst = 1'b0;
		chk(wake_en, 1'b0);
		chk({power_state, deep_sleep, cfg_rsp.ack}, 4'h0);
		cfg(1'b0, 8'h84, 4'hF, 32'h0);
		chk(cfg_rsp.rdata, 32'h0);
		$display("sleep test done");
		complete_run();
	end
endmodule : tb_top
